// [hw/clock_gating_control.v]
`timescale 1ns/1ns
`default_nettype none
`include "clock_gating_control_consts.vh"
module clock_gating_control (
  // clock and reset
  input  wire                    I_CLOCK,
  input  wire                    I_ARST_N,
  // register port
  input  wire [`CGC_ADDR_W-1:0]  I_ADDR,
  input  wire                    I_WR,
  input  wire                    I_RD,
  input  wire [31:0]             I_WDATA,
  output wire [31:0]             O_RDATA,
  // wake-up, usb power and oscillator status pins
  input  wire                    I_WAKE_ANY,
  input  wire                    I_WAKE_USB,
  input  wire                    I_USB_ENGINE_POWER_ENABLE,
  input  wire                    I_PLL_LOCKED,
  // oscillator controls
  output wire                    O_RING_OSC_ENABLE,
  output wire                    O_PLL_ENABLE,
  output wire                    O_SYSCLK_SEL_PLL,
  // gated peripheral clocks
  output wire                    O_TIMER_CLK,
  output wire                    O_BUS_SRAM_CLK,
  output wire                    O_MEDIA_DATA_UNIT_CLK,
  output wire                    O_CIPHER_CLK,
  output wire                    O_SPI_MASTER_CLK,
  output wire                    O_SMART_CARD_CLK,
  output wire                    O_UART_CLK,
  output wire                    O_USB_ENGINE_CLK,
  output wire                    O_CARD_CTRL_TWO_CLK,
  output wire                    O_CARD_CTRL_ONE_CLK,
  // peripheral power and reset controls
  output wire [`CGC_NUM_GATES-1:0] O_LOW_POWER,
  output wire                    O_USB_PHY_ON,
  output wire                    O_USB_DEV_CTRL_RST
);

  // pin synchronisers
  reg [1:0] wake_any_sync_ff;
  reg [1:0] wake_usb_sync_ff;
  reg [1:0] usb_pwr_sync_ff;
  reg [1:0] pll_lock_sync_ff;

  always @(posedge I_CLOCK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      wake_any_sync_ff <= 2'h0;
      wake_usb_sync_ff <= 2'h0;
      usb_pwr_sync_ff  <= 2'h0;
      pll_lock_sync_ff <= 2'h0;
    end else begin
      wake_any_sync_ff <= {wake_any_sync_ff[0], I_WAKE_ANY};
      wake_usb_sync_ff <= {wake_usb_sync_ff[0], I_WAKE_USB};
      usb_pwr_sync_ff  <= {usb_pwr_sync_ff[0], I_USB_ENGINE_POWER_ENABLE};
      pll_lock_sync_ff <= {pll_lock_sync_ff[0], I_PLL_LOCKED};
    end
  end

  wire wake_any  = wake_any_sync_ff[1];
  wire wake_usb  = wake_usb_sync_ff[1];
  wire usb_pwr   = usb_pwr_sync_ff[1];
  wire pll_lock  = pll_lock_sync_ff[1];

  // registers
  reg        ring_osc_enable_ff;
  reg        pll_enable_ff;
  reg [31:0] periph_en_ff;
  reg        usb_rst_ff;
  reg [3:0]  usb_rst_cnt_ff;
  reg        sel_pll_ff;
  reg [31:0] rdata_ff;

  reg        nxt_ring_osc_enable;
  reg        nxt_pll_enable;
  reg [31:0] nxt_periph_en;

  wire wr_osc    = I_WR & (I_ADDR == `CGC_OFS_OSC_CTRL);
  wire wr_periph = I_WR & (I_ADDR == `CGC_OFS_PERIPH_EN);
  wire usb_gate  = periph_en_ff[`CGC_BIT_USB];
  // usb resume counts only when the engine is clocked and powered
  wire usb_wake_ok = wake_usb & usb_pwr & usb_gate;
  wire any_wake    = wake_any | usb_wake_ok;

  always @* begin
    nxt_ring_osc_enable = ring_osc_enable_ff;
    nxt_pll_enable      = pll_enable_ff;
    nxt_periph_en       = periph_en_ff;
    if (wr_osc) begin
      nxt_ring_osc_enable = I_WDATA[`CGC_BIT_RING_EN];
      nxt_pll_enable      = I_WDATA[`CGC_BIT_PLL_EN];
    end
    // wake-up sets win over a clearing write
    if (any_wake) begin
      nxt_ring_osc_enable = 1'b1;
    end
    if (usb_wake_ok) begin
      nxt_pll_enable = 1'b1;
    end
    if (any_wake && pll_enable_ff) begin
      nxt_pll_enable = 1'b1;
    end
    if (wr_periph) begin
      nxt_periph_en = I_WDATA & `CGC_PERIPH_MASK;
    end
  end

  always @(posedge I_CLOCK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      ring_osc_enable_ff <= `CGC_RING_EN_RESET;
      pll_enable_ff      <= `CGC_PLL_EN_RESET;
      periph_en_ff       <= `CGC_PERIPH_RESET;
    end else begin
      ring_osc_enable_ff <= nxt_ring_osc_enable;
      pll_enable_ff      <= nxt_pll_enable;
      periph_en_ff       <= nxt_periph_en;
    end
  end

  // one-time reset pulse to the usb device controller
  localparam [1:0] USB_RST_WAIT = 2'h0; // engine gate not yet set since reset
  localparam [1:0] USB_RST_BUSY = 2'h1; // pulse running
  localparam [1:0] USB_RST_DONE = 2'h2; // pulse issued, never again
  reg [1:0] usb_rst_state_ff;
  reg [1:0] nxt_usb_rst_state;
  reg [3:0] nxt_usb_rst_cnt;

  always @* begin
    nxt_usb_rst_state = usb_rst_state_ff;
    nxt_usb_rst_cnt   = usb_rst_cnt_ff;
    case (usb_rst_state_ff)
      USB_RST_WAIT: begin
        if (usb_gate) begin
          nxt_usb_rst_state = USB_RST_BUSY;
          nxt_usb_rst_cnt   = `CGC_USB_RST_CYC;
        end
      end
      USB_RST_BUSY: begin
        if (usb_rst_cnt_ff == `CGC_USB_RST_LAST) begin
          nxt_usb_rst_state = USB_RST_DONE;
        end
        nxt_usb_rst_cnt = usb_rst_cnt_ff - 4'h1;
      end
      USB_RST_DONE: begin
        nxt_usb_rst_cnt = 4'h0;
      end
      default: begin
        nxt_usb_rst_state = USB_RST_DONE;
        nxt_usb_rst_cnt   = 4'h0;
      end
    endcase
  end

  always @(posedge I_CLOCK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      usb_rst_state_ff <= USB_RST_WAIT;
      usb_rst_cnt_ff   <= 4'h0;
      usb_rst_ff       <= 1'b0;
    end else begin
      usb_rst_state_ff <= nxt_usb_rst_state;
      usb_rst_cnt_ff   <= nxt_usb_rst_cnt;
      usb_rst_ff       <= (nxt_usb_rst_state == USB_RST_BUSY);
    end
  end

  // system clock select follows a running, locked pll
  always @(posedge I_CLOCK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      sel_pll_ff <= 1'b0;
    end else begin
      sel_pll_ff <= pll_enable_ff & pll_lock;
    end
  end

  // read data with reserved bits at zero
  always @(posedge I_CLOCK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      rdata_ff <= 32'h00000000;
    end else if (I_RD && I_ADDR == `CGC_OFS_OSC_CTRL) begin
      rdata_ff <= 32'h00000000;
      rdata_ff[`CGC_BIT_RING_EN] <= ring_osc_enable_ff;
      rdata_ff[`CGC_BIT_PLL_EN]  <= pll_enable_ff;
      rdata_ff[`CGC_BIT_STABLE]  <= pll_enable_ff & pll_lock;
    end else if (I_RD && I_ADDR == `CGC_OFS_PERIPH_EN) begin
      rdata_ff <= periph_en_ff & `CGC_PERIPH_MASK;
    end else begin
      rdata_ff <= 32'h00000000;
    end
  end

  assign O_RDATA            = rdata_ff;
  assign O_RING_OSC_ENABLE  = ring_osc_enable_ff;
  assign O_PLL_ENABLE       = pll_enable_ff;
  assign O_SYSCLK_SEL_PLL   = sel_pll_ff;
  assign O_USB_PHY_ON       = usb_gate;
  assign O_USB_DEV_CTRL_RST = usb_rst_ff;

  // per-peripheral enables straight from the enable register
  wire timer_en    = periph_en_ff[`CGC_BIT_TIMER];
  wire sram_en     = periph_en_ff[`CGC_BIT_SRAM];
  wire media_en    = periph_en_ff[`CGC_BIT_MEDIA];
  wire cipher_en   = periph_en_ff[`CGC_BIT_CIPHER];
  wire spi_en      = periph_en_ff[`CGC_BIT_SPI];
  wire smart_en    = periph_en_ff[`CGC_BIT_SMART];
  wire uart_en     = periph_en_ff[`CGC_BIT_UART];
  wire usb_en      = periph_en_ff[`CGC_BIT_USB];
  wire card_two_en = periph_en_ff[`CGC_BIT_CARD_TWO];
  wire card_one_en = periph_en_ff[`CGC_BIT_CARD_ONE];

  // low-power requests, timer first down to card controller one
  reg  [`CGC_NUM_GATES-1:0] low_power_ff;
  wire [`CGC_NUM_GATES-1:0] nxt_low_power;

  assign nxt_low_power = ~{timer_en,
                           sram_en,
                           media_en,
                           cipher_en,
                           spi_en,
                           smart_en,
                           uart_en,
                           usb_en,
                           card_two_en,
                           card_one_en};

  always @(posedge I_CLOCK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      low_power_ff <= `CGC_LOW_POWER_RESET;
    end else begin
      low_power_ff <= nxt_low_power;
    end
  end

  assign O_LOW_POWER = low_power_ff;

  // one glitch-free gate per peripheral clock
  glitch_free_gate #(.INIT_EN (`CGC_GATE_RESET)) u_timer_gate (
    .i_clk    (I_CLOCK),
    .i_arst_n (I_ARST_N),
    .i_enable (timer_en),
    .o_gclk   (O_TIMER_CLK)
  );

  glitch_free_gate #(.INIT_EN (`CGC_GATE_RESET)) u_sram_gate (
    .i_clk    (I_CLOCK),
    .i_arst_n (I_ARST_N),
    .i_enable (sram_en),
    .o_gclk   (O_BUS_SRAM_CLK)
  );

  glitch_free_gate #(.INIT_EN (`CGC_GATE_RESET)) u_media_gate (
    .i_clk    (I_CLOCK),
    .i_arst_n (I_ARST_N),
    .i_enable (media_en),
    .o_gclk   (O_MEDIA_DATA_UNIT_CLK)
  );

  // cipher sram clock is not gated here
  glitch_free_gate #(.INIT_EN (`CGC_GATE_RESET)) u_cipher_gate (
    .i_clk    (I_CLOCK),
    .i_arst_n (I_ARST_N),
    .i_enable (cipher_en),
    .o_gclk   (O_CIPHER_CLK)
  );

  glitch_free_gate #(.INIT_EN (`CGC_GATE_RESET)) u_spi_gate (
    .i_clk    (I_CLOCK),
    .i_arst_n (I_ARST_N),
    .i_enable (spi_en),
    .o_gclk   (O_SPI_MASTER_CLK)
  );

  glitch_free_gate #(.INIT_EN (`CGC_GATE_RESET)) u_smart_gate (
    .i_clk    (I_CLOCK),
    .i_arst_n (I_ARST_N),
    .i_enable (smart_en),
    .o_gclk   (O_SMART_CARD_CLK)
  );

  glitch_free_gate #(.INIT_EN (`CGC_GATE_RESET)) u_uart_gate (
    .i_clk    (I_CLOCK),
    .i_arst_n (I_ARST_N),
    .i_enable (uart_en),
    .o_gclk   (O_UART_CLK)
  );

  glitch_free_gate #(.INIT_EN (`CGC_GATE_RESET)) u_usb_gate (
    .i_clk    (I_CLOCK),
    .i_arst_n (I_ARST_N),
    .i_enable (usb_en),
    .o_gclk   (O_USB_ENGINE_CLK)
  );

  glitch_free_gate #(.INIT_EN (`CGC_GATE_RESET)) u_card_two_gate (
    .i_clk    (I_CLOCK),
    .i_arst_n (I_ARST_N),
    .i_enable (card_two_en),
    .o_gclk   (O_CARD_CTRL_TWO_CLK)
  );

  glitch_free_gate #(.INIT_EN (`CGC_GATE_RESET)) u_card_one_gate (
    .i_clk    (I_CLOCK),
    .i_arst_n (I_ARST_N),
    .i_enable (card_one_en),
    .o_gclk   (O_CARD_CTRL_ONE_CLK)
  );

endmodule // clock_gating_control
`default_nettype wire

// [hw/clock_gating_control_consts.vh]
// Overview of operation
// - oscillator control bit 2 enables ring oscillator
// - any wake-up event sets ring oscillator enable
// - ring enable clear ignored during wake-up events
// - usb wake sets pll enable if powered
// - pll enable clear ignored during wake-up events
// - read-only bit 0 reports pll stable
// - bit 14 gates timer clock
// - bit 13 gates bus sram clock
// - bit 12 gates media data unit clock
// - bit 11 gates cipher logic, not sram
// - bit 10 gates spi master clock
// - bit 9 gates smart card clock
// - bit 8 gates uart clock
// - bit 7 clear stops usb engine, phy off
// - usb resume ignored while usb engine gated
// - first usb engine enable resets device controller
// - bit 4 gates second card controller clock
// - bit 3 gates first card controller clock
// - cleared enable puts peripheral in low power
// - locked running pll selected as system clock
// - processor always wakes on ring oscillator; here the pll stays selected while enabled and locked
`ifndef CLOCK_GATING_CONTROL_CONSTS_VH
`define CLOCK_GATING_CONTROL_CONSTS_VH

`define CGC_ADDR_W        12
`define CGC_OFS_OSC_CTRL  12'h400
`define CGC_OFS_PERIPH_EN 12'h404
`define CGC_OSC_RESET     8'h06
`define CGC_PERIPH_RESET  32'h00000000
`define CGC_OSC_MASK      8'h06
`define CGC_PERIPH_MASK   32'h00007f98

`define CGC_BIT_STABLE    0
`define CGC_BIT_PLL_EN    1
`define CGC_BIT_RING_EN   2

`define CGC_BIT_CARD_ONE  3
`define CGC_BIT_CARD_TWO  4
`define CGC_BIT_USB       7
`define CGC_BIT_UART      8
`define CGC_BIT_SMART     9
`define CGC_BIT_SPI       10
`define CGC_BIT_CIPHER    11
`define CGC_BIT_MEDIA     12
`define CGC_BIT_SRAM      13
`define CGC_BIT_TIMER     14

`define CGC_NUM_GATES     10
`define CGC_USB_RST_CYC   4'h8
`define CGC_USB_RST_LAST  4'h1
`define CGC_RING_EN_RESET 1'b1
`define CGC_PLL_EN_RESET  1'b1
`define CGC_GATE_RESET    1'b0
`define CGC_LOW_POWER_RESET 10'h3ff

`endif

// [hw/glitch_free_gate.v]
`timescale 1ns/1ns
`default_nettype none
// enable is retimed on the falling edge, so the gated clock only switches while low
module glitch_free_gate #(
  parameter [0:0] INIT_EN = 1'b0
) (
  // clock and reset
  input  wire i_clk,
  input  wire i_arst_n,
  // control
  input  wire i_enable,
  // gated clock
  output wire o_gclk
);

  reg enable_ff;

  always @(negedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      enable_ff <= INIT_EN;
    end else begin
      enable_ff <= i_enable;
    end
  end

  assign o_gclk = i_clk & enable_ff;

endmodule // glitch_free_gate
`default_nettype wire

// [verification/clock_gating_control_sva.sv]
`timescale 1ns/1ns
`default_nettype none
module clock_gating_control_sva (
  // clock, reset and register port
  input wire logic        I_CLOCK, I_ARST_N, I_RD, I_WR,
  input wire logic [11:0] I_ADDR,
  input wire logic [31:0] O_RDATA,
  // wake and oscillator status
  input wire logic        I_WAKE_ANY, I_PLL_LOCKED,
  // outputs watched
  input wire logic        O_RING_OSC_ENABLE, O_PLL_ENABLE, O_SYSCLK_SEL_PLL, O_USB_PHY_ON,
  input wire logic        O_USB_DEV_CTRL_RST, O_TIMER_CLK, O_USB_ENGINE_CLK, O_CARD_CTRL_ONE_CLK
);
  logic seen_ff;
  always_ff @(posedge I_CLOCK or negedge I_ARST_N)
    if (!I_ARST_N) seen_ff <= 1'b0;
    else if (O_USB_DEV_CTRL_RST) seen_ff <= 1'b1;
  default clocking @(posedge I_CLOCK); endclocking
  default disable iff (!I_ARST_N);
  chk_rdata_idle_zero: assert property (!$past(I_RD) |-> O_RDATA == 32'h0)
    else $error("read data not zero while idle");
  chk_osc_read_bits: assert property ($past(I_RD) && $past(I_ADDR) == 12'h400 |->
    O_RDATA[31:1] == {29'h0, $past(O_RING_OSC_ENABLE), $past(O_PLL_ENABLE)})
    else $error("oscillator control read wrong");
  chk_periph_rsvd_zero: assert property ($past(I_RD) && $past(I_ADDR) == 12'h404 |->
    (O_RDATA & ~32'h7f98) == 32'h0) else $error("reserved enable bits not zero");
  chk_wake_ring_on: assert property (I_WAKE_ANY [*4] |=> O_RING_OSC_ENABLE)
    else $error("ring oscillator off during wake");
  chk_pll_hw_cause: assert property ($rose(O_PLL_ENABLE) && !$past(I_WR) |-> $past(O_USB_PHY_ON))
    else $error("pll started with usb engine gated");
  chk_pll_select_on: assert property ((O_PLL_ENABLE && I_PLL_LOCKED) [*4] |=> O_SYSCLK_SEL_PLL)
    else $error("locked pll not selected");
  chk_pll_select_off: assert property (!O_PLL_ENABLE |=> !O_SYSCLK_SEL_PLL)
    else $error("disabled pll selected");
  chk_gate_low_edge: assert property (!(O_TIMER_CLK || O_USB_ENGINE_CLK || O_CARD_CTRL_ONE_CLK))
    else $error("gated clock high while source low");
  chk_usb_rst_len: assert property ($rose(O_USB_DEV_CTRL_RST) |->
    O_USB_DEV_CTRL_RST [*8] ##1 !O_USB_DEV_CTRL_RST) else $error("controller reset length wrong");
  chk_usb_rst_once: assert property ($rose(O_USB_DEV_CTRL_RST) |-> !seen_ff)
    else $error("controller reset repeated");
endmodule // clock_gating_control_sva
`default_nettype wire

// [verification/clock_gating_control_tb.sv]
`timescale 1ns/1ns
`default_nettype none
module clock_gating_control_tb;
  logic        I_CLOCK = 0, I_ARST_N = 0, I_WR = 0, I_RD = 0, rd_ff = 0;
  logic        I_WAKE_ANY = 0, I_WAKE_USB = 0, pwr = 0, lock = 0;
  logic [11:0] I_ADDR = 0;
  logic [31:0] I_WDATA = 0, d, exp_q[$];
  wire  [31:0] O_RDATA;
  wire  [9:0]  gclk, lp;
  wire         ring, pll, sel, phy, urst;
  int          err_count = 0, checks_done = 0;
  integer      seed = 1301;
  always #25 I_CLOCK = ~I_CLOCK;
  clock_gating_control i_clock_gating_control (.I_CLOCK(I_CLOCK), .I_ARST_N(I_ARST_N),
    .I_ADDR(I_ADDR), .I_WR(I_WR), .I_RD(I_RD), .I_WDATA(I_WDATA), .O_RDATA(O_RDATA),
    .I_WAKE_ANY(I_WAKE_ANY), .I_WAKE_USB(I_WAKE_USB), .I_USB_ENGINE_POWER_ENABLE(pwr),
    .I_PLL_LOCKED(lock), .O_RING_OSC_ENABLE(ring), .O_PLL_ENABLE(pll), .O_SYSCLK_SEL_PLL(sel),
    .O_TIMER_CLK(gclk[9]), .O_BUS_SRAM_CLK(gclk[8]), .O_MEDIA_DATA_UNIT_CLK(gclk[7]),
    .O_CIPHER_CLK(gclk[6]), .O_SPI_MASTER_CLK(gclk[5]), .O_SMART_CARD_CLK(gclk[4]),
    .O_UART_CLK(gclk[3]), .O_USB_ENGINE_CLK(gclk[2]), .O_CARD_CTRL_TWO_CLK(gclk[1]),
    .O_CARD_CTRL_ONE_CLK(gclk[0]), .O_LOW_POWER(lp), .O_USB_PHY_ON(phy), .O_USB_DEV_CTRL_RST(urst));
  task automatic check(input string name, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", name, e, g);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] v);
    @(negedge I_CLOCK); I_ADDR = a; I_WDATA = v; I_WR = 1;
    @(negedge I_CLOCK); I_WR = 0;
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    @(negedge I_CLOCK); I_ADDR = a; I_RD = 1; exp_q.push_back(e);
    @(negedge I_CLOCK); I_RD = 0;
  endtask
  task automatic gates(input logic [31:0] v);
    repeat (2) @(posedge I_CLOCK);
    #5 check("gated clocks", {22'h0, v[14:7], v[4:3]}, {22'h0, gclk});
    check("low power", {22'h0, ~v[14:7], ~v[4:3]}, {22'h0, lp});
  endtask
  task automatic idle(input int n);
    repeat (n) @(negedge I_CLOCK);
  endtask
  task automatic finish_test;
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // read results land on the taking edge and are checked at the falling edge after it
  always @(posedge I_CLOCK) rd_ff <= I_RD;
  always @(negedge I_CLOCK) if (rd_ff) check("read data", exp_q.pop_front(), O_RDATA);
  initial begin
    idle(5);
    I_ARST_N = 1;
    rd(12'h400, 32'h06);
    rd(12'h404, 32'h0);
    rd(12'h408, 32'h0);
    check("controller reset", 32'h0, urst);
    check("clock select", 32'h0, sel);
    $display("reset values done");
    wr(12'h404, 32'hffffffff);
    rd(12'h404, 32'h7f98);
    gates(32'h7f98);
    check("controller reset", 32'h1, urst);
    check("usb phy", 32'h1, phy);
    repeat (8) begin
      d = $random(seed);
      wr(12'h404, d);
      gates(d);
      rd(12'h404, d & 32'h7f98);
    end
    $display("peripheral gates done");
    wr(12'h404, 32'h0);
    check("usb phy", 32'h0, phy);
    wr(12'h400, 32'h0);
    rd(12'h400, 32'h0);
    I_WAKE_ANY = 1;
    idle(5);
    rd(12'h400, 32'h04);
    check("ring enable", 32'h1, ring);
    wr(12'h400, 32'h0);
    rd(12'h400, 32'h04);
    wr(12'h400, 32'h02);
    wr(12'h400, 32'h0);
    rd(12'h400, 32'h06);
    check("pll enable", 32'h1, pll);
    I_WAKE_ANY = 0;
    pwr = 1;
    I_WAKE_USB = 1;
    idle(5);
    wr(12'h400, 32'h0);
    idle(5);
    rd(12'h400, 32'h0);
    check("pll enable", 32'h0, pll);
    wr(12'h404, 32'h80);
    idle(5);
    rd(12'h400, 32'h06);
    check("usb phy", 32'h1, phy);
    wr(12'h400, 32'h0);
    rd(12'h400, 32'h06);
    lock = 1;
    idle(5);
    rd(12'h400, 32'h07);
    check("clock select", 32'h1, sel);
    I_WAKE_USB = 0;
    pwr = 0;
    lock = 0;
    idle(5);
    wr(12'h400, 32'h0);
    I_WAKE_USB = 1;
    idle(5);
    rd(12'h400, 32'h0);
    wr(12'h400, 32'h04);
    rd(12'h400, 32'h04);
    check("controller reset", 32'h0, urst);
    $display("wake handling done");
    idle(2);
    finish_test;
  end
  initial begin
    #50000;
    err_count++;
    finish_test;
  end
endmodule // clock_gating_control_tb
bind clock_gating_control clock_gating_control_sva i_clock_gating_control_sva (
  .I_CLOCK(I_CLOCK), .I_ARST_N(I_ARST_N), .I_RD(I_RD), .I_WR(I_WR), .I_ADDR(I_ADDR),
  .O_RDATA(O_RDATA), .I_WAKE_ANY(I_WAKE_ANY), .I_PLL_LOCKED(I_PLL_LOCKED),
  .O_RING_OSC_ENABLE(O_RING_OSC_ENABLE), .O_PLL_ENABLE(O_PLL_ENABLE),
  .O_SYSCLK_SEL_PLL(O_SYSCLK_SEL_PLL), .O_USB_PHY_ON(O_USB_PHY_ON),
  .O_USB_DEV_CTRL_RST(O_USB_DEV_CTRL_RST), .O_TIMER_CLK(O_TIMER_CLK),
  .O_USB_ENGINE_CLK(O_USB_ENGINE_CLK), .O_CARD_CTRL_ONE_CLK(O_CARD_CTRL_ONE_CLK));
`default_nettype wire
